/* sensor_measure_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the measurement block.
`ifndef SENSOR_MEASURE_CFG_SVH
`define SENSOR_MEASURE_CFG_SVH

// Byte addresses of the registers on the bus.
`define ADR_STATUS_CONTROL 8'h40
`define ADR_MEASURE_CONTROL 8'h44
`define ADR_INITIAL_SETTLE 8'h48
`define ADR_SUBSEQUENT_SETTLE 8'h4c
`define ADR_EVENT_STATUS 8'h50
`define ADR_EVENT_MASK 8'h54

// Field positions of the status and control register.
`define SC_FLAG_BIT 7
`define SC_ACK_BIT 6
`define SC_IE_BIT 5
`define SC_SEN_BIT 4
`define SC_LOW_POWER_DIRECT_SEL_BIT 3

// Field positions of the measure control register.
`define MC_ENABLE_BIT 7
`define MC_CAPTURE_BIT 6

// Field positions of the event status and mask registers.
`define EV_SETTLE_BIT 0
`define EV_ACQ_DONE_BIT 1
`define EV_TRIGGER_BIT 2
`define EV_WIDTH 3

// Reset values.
`define RST_BYTE 8'h00
`define RST_EVENTS 3'h0
`define RST_DELAY 8'h00

// Settling delays count ticks of one microsecond.
`define CLK_PERIOD_NS 20
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_LAST 6'((`TICK_CYCLES) - 1)

`endif

/* sensor_measure_pkg.sv */
// Types shared by the measurement status and control block.
package sensor_measure_pkg;

    // One-hot states of the settle and trigger sequencer.
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_SETTLE  = 3'b010,
        ST_CONVERT = 3'b100
    } seq_state_t;

    // Control and status bits held by the block.
    typedef struct packed {
        logic settle_irq_flag;
        logic settle_irq_enable;
        logic acquisition_enable;
        logic low_power_direct_sel;
        logic measure_enable;
        logic capture_trigger;
    } ctrl_t;

    // One register access as seen by the decoder.
    typedef struct packed {
        logic       wr;
        logic [7:0] adr;
        logic [7:0] data;
    } reg_access_t;

endpackage

/* sensor_measure_status_ctrl.sv */
// Status and control logic of the sensor measurement interface with a Wishbone register port.
`include "sensor_measure_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sensor_measure_status_ctrl (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave.
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Processor and converter side.
    input  wire logic        deep_sleep_state_i,
    input  wire logic        conversion_complete_i,
    output logic             cap_to_voltage_conv_en_o,
    output logic             adc_trigger_o,
    output logic             settle_irq_o,
    output logic             irq_o
);

    // Held control bits, sequencer state and settle counter.
    sensor_measure_pkg::ctrl_t      ctrl;
    sensor_measure_pkg::ctrl_t      next_ctrl;
    sensor_measure_pkg::seq_state_t state;
    sensor_measure_pkg::seq_state_t next_state;
    sensor_measure_pkg::reg_access_t acc;
    logic [7:0]                     initial_settle_delay;
    logic [7:0]                     subsequent_settle_period;
    logic [7:0]                     settle_cnt;
    logic [7:0]                     next_settle_cnt;
    logic [5:0]                     tick_cnt;
    logic [`EV_WIDTH-1:0]           ev_status;
    logic [`EV_WIDTH-1:0]           ev_mask;
    logic                           trig_pulse;
    logic                           acq_done;
    logic                           settle_end;

    // Bus decode. A write takes effect on the edge at which the master samples ack.
    wire logic        req        = cyc_i & stb_i;
    wire logic        wr_fire    = req & we_i & ack_o & sel_i[0];
    wire logic [7:0]  wd         = dat_i[7:0];
    assign acc.wr   = wr_fire;
    assign acc.adr  = {adr_i[7:2], 2'b00};
    assign acc.data = wd;

    wire logic wr_sc  = acc.wr & (acc.adr == `ADR_STATUS_CONTROL);
    wire logic wr_mc  = acc.wr & (acc.adr == `ADR_MEASURE_CONTROL);
    wire logic wr_isd = acc.wr & (acc.adr == `ADR_INITIAL_SETTLE);
    wire logic wr_sp  = acc.wr & (acc.adr == `ADR_SUBSEQUENT_SETTLE);
    wire logic wr_evs = acc.wr & (acc.adr == `ADR_EVENT_STATUS);
    wire logic wr_evm = acc.wr & (acc.adr == `ADR_EVENT_MASK);

    // Readback images; the acknowledge bit and bits 2 to 0 always read zero.
    wire logic [7:0] sc_rd = {ctrl.settle_irq_flag, 1'b0,
                              ctrl.settle_irq_enable,
                              ctrl.acquisition_enable,
                              ctrl.low_power_direct_sel, 3'b000};
    wire logic [7:0] mc_rd = {ctrl.measure_enable, ctrl.capture_trigger, 6'h00};

    // Read data selection; an unmapped address answers with zero.
    wire logic [7:0] rd_byte =
        (acc.adr == `ADR_STATUS_CONTROL)    ? sc_rd :
        (acc.adr == `ADR_MEASURE_CONTROL)   ? mc_rd :
        (acc.adr == `ADR_INITIAL_SETTLE)    ? initial_settle_delay :
        (acc.adr == `ADR_SUBSEQUENT_SETTLE) ? subsequent_settle_period :
        (acc.adr == `ADR_EVENT_STATUS)      ? {5'h00, ev_status} :
        (acc.adr == `ADR_EVENT_MASK)        ? {5'h00, ev_mask} : 8'h00;

    // Mode summaries used by the write guards, the sequencer, the capture self-clear and the trigger.
    wire logic idle_all   = ~ctrl.acquisition_enable & ~ctrl.measure_enable
                            & ~ctrl.low_power_direct_sel;
    wire logic lp_run     = ctrl.low_power_direct_sel & ctrl.measure_enable
                            & ctrl.capture_trigger;
    wire logic lp_capture = ctrl.low_power_direct_sel & ctrl.capture_trigger;
    wire logic direct_cap = ctrl.capture_trigger & ~ctrl.low_power_direct_sel
                            & ctrl.measure_enable;
    wire logic tick       = (tick_cnt == `TICK_LAST);
    wire logic cnt_zero   = (settle_cnt == 8'h00);

    // Write guards on the status and control register.
    wire logic sen_start  = wr_sc & wd[`SC_SEN_BIT] & idle_all;
    wire logic low_power_direct_sel_set   = wr_sc & wd[`SC_LOW_POWER_DIRECT_SEL_BIT] & ~ctrl.acquisition_enable
                            & ~ctrl.measure_enable;
    wire logic low_power_direct_sel_clr   = wr_sc & ~wd[`SC_LOW_POWER_DIRECT_SEL_BIT] & ctrl.low_power_direct_sel
                            & ~ctrl.measure_enable;
    wire logic flag_ack   = wr_sc & wd[`SC_ACK_BIT];

    // Write guards on the measure control register.
    wire logic men_set    = wr_mc & wd[`MC_ENABLE_BIT] & ~ctrl.acquisition_enable
                            & ~lp_capture;
    wire logic men_clr    = wr_mc & ~wd[`MC_ENABLE_BIT]
                            & ~(ctrl.capture_trigger & ~ctrl.low_power_direct_sel);
    wire logic cap_set    = wr_mc & wd[`MC_CAPTURE_BIT] & ~ctrl.acquisition_enable
                            & (ctrl.measure_enable | wd[`MC_ENABLE_BIT]);

    // The flag only sets for an auto-mode settle end with everything in its favour.
    wire logic flag_set   = settle_end & ctrl.acquisition_enable
                            & ctrl.settle_irq_enable
                            & ~ctrl.low_power_direct_sel
                            & ~deep_sleep_state_i;

    // Microsecond tick divider for the settle counter.
    always_ff @(posedge clk_i) begin
        if (rst_i || tick) begin
            tick_cnt <= 6'h00;
        end else begin
            tick_cnt <= tick_cnt + 6'h01;
        end
    end

    // Sequencer: settle delay, trigger, then wait for conversion or settle again.
    always_comb begin
        next_state      = state;
        next_settle_cnt = settle_cnt;
        trig_pulse      = 1'b0;
        acq_done        = 1'b0;
        settle_end      = 1'b0;
        case (state)
            sensor_measure_pkg::ST_IDLE: begin
                if (ctrl.acquisition_enable || lp_run) begin
                    next_state      = sensor_measure_pkg::ST_SETTLE;
                    next_settle_cnt = initial_settle_delay;
                end
            end
            sensor_measure_pkg::ST_SETTLE: begin
                // Low-power periods stop once measure enable drops, so no trigger meets an off converter.
                if (!ctrl.acquisition_enable && !lp_run) begin
                    next_state = sensor_measure_pkg::ST_IDLE;
                end else if (tick && cnt_zero) begin
                    settle_end = 1'b1;
                    trig_pulse = 1'b1;
                    if (ctrl.acquisition_enable) begin
                        next_state = sensor_measure_pkg::ST_CONVERT;
                    end else begin
                        // Next period runs alongside the conversion.
                        next_settle_cnt = subsequent_settle_period;
                    end
                end else if (tick) begin
                    next_settle_cnt = settle_cnt - 8'h01;
                end
            end
            sensor_measure_pkg::ST_CONVERT: begin
                if (conversion_complete_i) begin
                    acq_done   = 1'b1;
                    next_state = sensor_measure_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = sensor_measure_pkg::ST_IDLE;
            end
        endcase
    end

    // Next values of the held control bits.
    always_comb begin
        next_ctrl = ctrl;
        if (wr_sc) begin
            next_ctrl.settle_irq_enable = wd[`SC_IE_BIT];
        end
        if (sen_start) begin
            next_ctrl.acquisition_enable = 1'b1;
        end else if (acq_done) begin
            next_ctrl.acquisition_enable = 1'b0;
        end
        if (low_power_direct_sel_set) begin
            next_ctrl.low_power_direct_sel = 1'b1;
        end else if (low_power_direct_sel_clr) begin
            next_ctrl.low_power_direct_sel = 1'b0;
        end
        if (men_set) begin
            next_ctrl.measure_enable = 1'b1;
        end else if (men_clr) begin
            next_ctrl.measure_enable = 1'b0;
        end
        if (low_power_direct_sel_clr) begin
            next_ctrl.capture_trigger = 1'b0;
        end else if (direct_cap) begin
            // Direct mode: one full cycle set, then self-clear.
            next_ctrl.capture_trigger = 1'b0;
        end else if (cap_set) begin
            next_ctrl.capture_trigger = 1'b1;
        end
        if (flag_set) begin
            next_ctrl.settle_irq_flag = 1'b1;
        end else if (flag_ack) begin
            next_ctrl.settle_irq_flag = 1'b0;
        end
    end

    // Control bits and sequencer registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl       <= '0;
            state      <= sensor_measure_pkg::ST_IDLE;
            settle_cnt <= `RST_DELAY;
        end else begin
            ctrl       <= next_ctrl;
            state      <= next_state;
            settle_cnt <= next_settle_cnt;
        end
    end

    // Settle interval settings; software times these writes itself.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            initial_settle_delay     <= `RST_DELAY;
            subsequent_settle_period <= `RST_DELAY;
        end else begin
            if (wr_isd) begin
                initial_settle_delay <= wd;
            end
            if (wr_sp) begin
                subsequent_settle_period <= wd;
            end
        end
    end

    // Event status bits; a new event wins over a write-one clear.
    wire logic [`EV_WIDTH-1:0] ev_in = {trig_pulse | direct_cap, acq_done, flag_set};
    wire logic [`EV_WIDTH-1:0] ev_clr = wr_evs ? wd[`EV_WIDTH-1:0] : `RST_EVENTS;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_status <= `RST_EVENTS;
            ev_mask   <= `RST_EVENTS;
        end else begin
            ev_status <= (ev_status & ~ev_clr) | ev_in;
            if (wr_evm) begin
                ev_mask <= wd[`EV_WIDTH-1:0];
            end
        end
    end

    // Bus answer: ack one cycle after the request, dropped the cycle after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req & ~ack_o;
            dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // Registered outputs toward the converter and the processor.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_to_voltage_conv_en_o <= 1'b0;
            adc_trigger_o            <= 1'b0;
            settle_irq_o             <= 1'b0;
            irq_o                    <= 1'b0;
        end else begin
            cap_to_voltage_conv_en_o <= ctrl.acquisition_enable
                                        | ctrl.measure_enable;
            adc_trigger_o            <= trig_pulse | direct_cap;
            settle_irq_o             <= ctrl.settle_irq_flag
                                        & ~ctrl.low_power_direct_sel
                                        & ~deep_sleep_state_i;
            irq_o                    <= |(ev_status & ev_mask);
        end
    end

endmodule

`default_nettype wire

/* sensor_measure_checker.sv */
// Concurrent property checker for the measurement status and control block.
`include "sensor_measure_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sensor_measure_checker (
    // Clock and reset.
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Register bus.
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Processor and converter side.
    input wire logic        deep_sleep_state_i,
    input wire logic        conversion_complete_i,
    input wire logic        cap_to_voltage_conv_en_o,
    input wire logic        adc_trigger_o,
    input wire logic        settle_irq_o,
    input wire logic        irq_o
);
    // All properties share the one clock and pause during reset.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Status register write with the acknowledge bit set, and a status register read.
    wire logic ack_wr = cyc_i && stb_i && we_i && sel_i[0] && ack_o
                        && adr_i == `ADR_STATUS_CONTROL && dat_i[`SC_ACK_BIT];
    wire logic sc_rd = ack_o && !we_i && adr_i == `ADR_STATUS_CONTROL;

    AST_ACK_ANSWER: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered in the next cycle");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("bus acknowledge longer than one cycle");
    AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("bus acknowledge without a request");
    AST_READ_ZERO: assert property (sc_rd |-> dat_o[`SC_ACK_BIT] == 1'b0
        && dat_o[2:0] == 3'h0 && dat_o[31:8] == 24'h0)
        else $error("status register unused bits not zero");
    AST_ACK_CLEARS: assert property (ack_wr |=> ##1 !settle_irq_o)
        else $error("settle interrupt still high after acknowledge");
    AST_SLEEP_MUTE: assert property (deep_sleep_state_i |=> !settle_irq_o)
        else $error("settle interrupt raised in stop mode");
    AST_TRIG_PULSE: assert property (adc_trigger_o |=> !adc_trigger_o)
        else $error("converter trigger longer than one cycle");
    AST_TRIG_CONV: assert property (adc_trigger_o |-> cap_to_voltage_conv_en_o)
        else $error("converter trigger while converter disabled");
endmodule

bind sensor_measure_status_ctrl sensor_measure_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .deep_sleep_state_i(deep_sleep_state_i), .conversion_complete_i(conversion_complete_i),
    .cap_to_voltage_conv_en_o(cap_to_voltage_conv_en_o), .adc_trigger_o(adc_trigger_o),
    .settle_irq_o(settle_irq_o), .irq_o(irq_o)
);
`default_nettype wire

/* adc_model.sv */
// Converter model that answers each trigger with a conversion-complete pulse.
`timescale 1ns/1ps
`default_nettype none

module adc_model (
    // Clock and reset.
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Trigger in, latency setting, completion out.
    input wire logic       trig_i,
    input wire logic [7:0] lat_i,
    output logic           done_o
);
    logic [7:0] cnt;

    // Reloads the latency on each trigger and pulses done for one cycle when it runs out.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt    <= 8'h00;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt == 8'h01);
            cnt    <= trig_i ? lat_i : (cnt != 8'h00 ? cnt - 8'h01 : 8'h00);
        end
    end
endmodule
`default_nettype wire

/* sensor_measure_status_ctrl_test.sv */
// Self-checking testbench of the measurement status and control block.
`include "sensor_measure_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end

module sensor_measure_status_ctrl_test;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, deep, cc, conv_en, trig, sirq, irq;
    logic [7:0]  adr_i, lat;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o;
    logic        ack_o;
    int          n_fail, n_compared, cycles, n, i;

    sensor_measure_status_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .deep_sleep_state_i(deep),
        .conversion_complete_i(cc), .cap_to_voltage_conv_en_o(conv_en),
        .adc_trigger_o(trig), .settle_irq_o(sirq), .irq_o(irq));
    adc_model u_adc (.clk_i(clk_i), .rst_i(rst_i), .trig_i(trig), .lat_i(lat), .done_o(cc));

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One classic bus cycle held until the acknowledge edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        q = dat_o[7:0];
        `CHECK(ack_o, 1'b1)
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        xfer(1'b0, a, 8'h00, q);
        `CHECK(q, e)
    endtask

    // Polls the status register until the acquisition bit drops.
    task automatic wait_idle();
        logic [7:0] q;
        int k;
        k = 0;
        do begin
            xfer(1'b0, `ADR_STATUS_CONTROL, 8'h00, q);
            k++;
        end while (q[`SC_SEN_BIT] !== 1'b0 && k < 100);
        `CHECK(q[`SC_SEN_BIT], 1'b0)
    endtask

    task automatic end_test(input string name);
        $display("test %s finished", name);
    endtask

    // Clock generation and hang guard.
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end

    // Main test sequence.
    initial begin
        rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00;
        sel_i = 4'hf; dat_i = 32'h0; deep = 1'b0; lat = 8'h14;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_rd(`ADR_STATUS_CONTROL, 8'h00);
        chk_rd(8'h7c, 8'h00);
        `CHECK(conv_en, 1'b0)
        end_test("reset");
        wr(`ADR_STATUS_CONTROL, 8'h30);
        for (n = 0; n < 300 && sirq !== 1'b1; n++) @(posedge clk_i);
        `CHECK(sirq, 1'b1)
        chk_rd(`ADR_STATUS_CONTROL, 8'hb0);
        `CHECK(conv_en, 1'b1)
        wait_idle();
        // Settle intervals are changed right after the conversion has completed.
        wr(`ADR_INITIAL_SETTLE, 8'h01);
        wr(`ADR_SUBSEQUENT_SETTLE, 8'h02);
        chk_rd(`ADR_INITIAL_SETTLE, 8'h01);
        chk_rd(`ADR_SUBSEQUENT_SETTLE, 8'h02);
        chk_rd(`ADR_STATUS_CONTROL, 8'ha0);
        wr(`ADR_STATUS_CONTROL, 8'h20);
        chk_rd(`ADR_STATUS_CONTROL, 8'ha0);
        wr(`ADR_STATUS_CONTROL, 8'h60);
        chk_rd(`ADR_STATUS_CONTROL, 8'h20);
        `CHECK(sirq, 1'b0)
        `CHECK(irq, 1'b0)
        chk_rd(`ADR_EVENT_STATUS, 8'h07);
        wr(`ADR_EVENT_MASK, 8'h07);
        repeat (2) @(posedge clk_i);
        `CHECK(irq, 1'b1)
        wr(`ADR_EVENT_STATUS, 8'h07);
        repeat (2) @(posedge clk_i);
        `CHECK(irq, 1'b0)
        end_test("auto");
        // Stop mode with the enable set, then run mode with the enable clear.
        for (i = 0; i < 2; i++) begin
            deep <= (i == 0);
            lat <= (i == 0) ? 8'h14 : 8'h02;
            wr(`ADR_STATUS_CONTROL, (i == 0) ? 8'h30 : 8'h10);
            wr(`ADR_MEASURE_CONTROL, 8'h80);
            chk_rd(`ADR_MEASURE_CONTROL, 8'h00);
            wait_idle();
            chk_rd(`ADR_STATUS_CONTROL, (i == 0) ? 8'h20 : 8'h00);
        end
        deep <= 1'b0;
        end_test("gating");
        // Low-power entry, refused early exit, then ordered exit.
        wr(`ADR_STATUS_CONTROL, 8'h08);
        wr(`ADR_MEASURE_CONTROL, 8'h80);
        wr(`ADR_MEASURE_CONTROL, 8'hc0);
        for (n = 0; n < 300 && trig !== 1'b1; n++) @(posedge clk_i);
        `CHECK(trig, 1'b1)
        chk_rd(`ADR_MEASURE_CONTROL, 8'hc0);
        wr(`ADR_STATUS_CONTROL, 8'h00);
        chk_rd(`ADR_STATUS_CONTROL, 8'h08);
        wr(`ADR_MEASURE_CONTROL, 8'h00);
        chk_rd(`ADR_MEASURE_CONTROL, 8'h40);
        wr(`ADR_STATUS_CONTROL, 8'h00);
        chk_rd(`ADR_MEASURE_CONTROL, 8'h00);
        chk_rd(`ADR_STATUS_CONTROL, 8'h00);
        end_test("low_power");
        // Full-power direct capture: one trigger, then the capture bit clears itself.
        wr(`ADR_MEASURE_CONTROL, 8'h80);
        wr(`ADR_MEASURE_CONTROL, 8'hc0);
        repeat (2) @(posedge clk_i);
        `CHECK(trig, 1'b1)
        `CHECK(conv_en, 1'b1)
        chk_rd(`ADR_MEASURE_CONTROL, 8'h80);
        wr(`ADR_MEASURE_CONTROL, 8'h00);
        chk_rd(`ADR_MEASURE_CONTROL, 8'h00);
        `CHECK(conv_en, 1'b0)
        end_test("direct");
        final_report();
    end
endmodule
`default_nettype wire
